// ==== rtl/timer_b_pkg.sv ====
// Shared constants for the event counter and pulse measurement timer channel
package timer_b_pkg;
  // Register byte offsets
  localparam logic [7:0] START_REG_OFFSET = 8'h00;
  localparam logic [7:0] MODE_REG_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_REG_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_CTRL_OFFSET = 8'h0c;
  // Start register fields
  localparam int START_PRESCALE_F2_BIT = 0;
  localparam int RUN_BIT_LOW = 5;
  localparam int RUN_BIT_HIGH = 7;
  // Mode register fields
  localparam int MODE_FIELD_LOW_BIT = 0;
  localparam int EDGE_SELECT_LOW_BIT = 2;
  localparam int EVENT_SOURCE_BIT = 4;
  localparam int OVERFLOW_FLAG_BIT = 5;
  localparam int CLOCK_SELECT_LOW_BIT = 6;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hdf;
  // Interrupt control register field
  localparam int IRQ_REQUEST_FLAG_BIT = 3;
  // Reset values
  localparam logic [7:0] START_REG_RESET = 8'h00;
  localparam logic [7:0] MODE_REG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // Mode field encodings
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_MEASURE = 2'h2;
  // Edge select encodings
  localparam logic [1:0] EDGE_FALLING = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // Count clock select encodings
  localparam logic [1:0] CLK_F1_F2 = 2'h0;
  localparam logic [1:0] CLK_F8 = 2'h1;
  localparam logic [1:0] CLK_F32 = 2'h2;
  localparam logic [1:0] CLK_FC32 = 2'h3;
  // Prescaler masks, tick when all masked bits are one
  localparam int PRESCALE_WIDTH = 5;
  localparam logic [4:0] PRESCALE_F2_MASK = 5'h01;
  localparam logic [4:0] PRESCALE_F8_MASK = 5'h07;
  localparam logic [4:0] PRESCALE_F32_MASK = 5'h1f;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    PHASE_STOPPED,
    PHASE_ARMED,
    PHASE_RUNNING
  } phase_type;
endpackage : timer_b_pkg

// ==== rtl/input_edge_sync.sv ====
// Two-stage synchroniser and edge detector for the channel input pin
`timescale 1ns/1ps
module input_edge_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pin
  input wire logic pin_async,
  // Same-clock edge pulses
  output logic rise_pulse,
  output logic fall_pulse
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      prev_q <= sync_q;
      rise_pulse <= sync_q & ~prev_q;
      fall_pulse <= ~sync_q & prev_q;
    end
  end
endmodule : input_edge_sync

// ==== rtl/timer_b_channel.sv ====
// Timer channel: event counter and pulse period/width measurement over APB
//
// Contract
// R01: Event mode counts selected pin edges or neighbour channel overflow/underflow events.
// R02: Event mode decrements per event; underflow reloads, keeps counting, requests interrupt.
// R03: Event mode divides the event rate by count value plus one.
// R04: Channel counts only while its run bit, bits 5-7 of a start register, is set.
// R05: Event mode count register read returns the live counter.
// R06: Event mode write loads counter and reload until first event, then reload only.
// R07: Software configures the input pin port as input before counting on it.
// R08: Measurement counter clocked by f1, f2, f8, f32 or subclock divided by 32.
// R09: Measurement counts up, captures into reload at effective edge, restarts from zero.
// R10: Measurement edges request interrupt, except the first edge after start.
// R11: Measurement overflow requests interrupt and sets the overflow flag together.
// R12: Mode register write after a later count tick clears overflow flag; run stays set.
// R13: Measurement count register read returns the reload register measurement.
// R14: Measurement read value is undefined before the second effective edge.
// R15: Measurement mode writes to count register change neither reload nor counter.
// R16: Edge select 00 measures falling-to-falling period, 10 measures both widths.
// R17: Interrupt request flag holds until accepted or written to zero by software.
// R18: Two-bit mode field selects timer, event counter or measurement operation; here mode 00 (timer) leaves the counter stopped.
// R19: Input is synchronised and edge-detected before acting on the counter.
// R20: Measurement counter signals overflow on wrap from all ones to zero.
`timescale 1ns/1ps
module timer_b_channel import timer_b_pkg::*; #(
  parameter int RUN_BIT = 5,
  parameter int CNT_WIDTH = 16
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count sources
  input wire logic channel_input_pin,
  input wire logic neighbour_event,
  input wire logic subclock_tick,
  // Interrupt controller side
  input wire logic irq_accept,
  output logic irq_request,
  // Events for the following channel
  output logic underflow_event,
  output logic overflow_event
);
  if (RUN_BIT < RUN_BIT_LOW || RUN_BIT > RUN_BIT_HIGH) begin : g_bad_run_bit
    $error("RUN_BIT must lie between 5 and 7");
  end
  if (CNT_WIDTH != 16) begin : g_bad_width
    $error("CNT_WIDTH must be 16");
  end

  function automatic logic tick_hit(input logic [4:0] div, input logic [4:0] mask);
    tick_hit = &(div | ~mask);
  endfunction : tick_hit

  function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic strobe);
    lane_merge = strobe ? new_v : old_v;
  endfunction : lane_merge

  logic [7:0] start_q;
  logic [7:0] mode_q;
  logic [CNT_WIDTH-1:0] counter_q;
  logic [CNT_WIDTH-1:0] reload_q;
  logic [4:0] prescale_q;
  logic ovf_armed_q;
  logic irq_flag_q;
  phase_type phase_q;
  logic pin_rise;
  logic pin_fall;

  // Access decode
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic addr_hit;
  logic wr_start;
  logic wr_mode;
  logic wr_count;
  logic wr_irq;
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_hit = (paddr == START_REG_OFFSET) || (paddr == MODE_REG_OFFSET) ||
                    (paddr == COUNT_REG_OFFSET) || (paddr == IRQ_CTRL_OFFSET);
  assign wr_access = access_phase & pwrite & addr_hit;
  assign wr_start = wr_access & (paddr == START_REG_OFFSET) & pstrb[0];
  assign wr_mode = wr_access & (paddr == MODE_REG_OFFSET) & pstrb[0];
  assign wr_count = wr_access & (paddr == COUNT_REG_OFFSET) & (|pstrb[1:0]);
  assign wr_irq = wr_access & (paddr == IRQ_CTRL_OFFSET) & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_hit;

  // Field views
  logic run;
  logic [1:0] mode_field;
  logic [1:0] edge_select;
  logic event_from_neighbour;
  logic [1:0] clock_select;
  logic event_mode;
  logic measure_mode;
  assign run = start_q[RUN_BIT]; // R04
  assign mode_field = mode_q[MODE_FIELD_LOW_BIT +: 2];
  assign edge_select = mode_q[EDGE_SELECT_LOW_BIT +: 2];
  assign event_from_neighbour = mode_q[EVENT_SOURCE_BIT];
  assign clock_select = mode_q[CLOCK_SELECT_LOW_BIT +: 2];
  assign event_mode = (mode_field == MODE_EVENT); // R18
  assign measure_mode = (mode_field == MODE_MEASURE); // R18

  input_edge_sync u_input_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(channel_input_pin),
    .rise_pulse(pin_rise),
    .fall_pulse(pin_fall)
  ); // R19

  // Edge qualification
  logic pin_edge;
  logic count_event;
  logic measure_edge;
  always_comb begin
    case (edge_select)
      EDGE_FALLING: pin_edge = pin_fall;
      EDGE_RISING: pin_edge = pin_rise;
      default: pin_edge = pin_rise | pin_fall;
    endcase
  end
  assign count_event = run & event_mode &
                       (event_from_neighbour ? neighbour_event : pin_edge); // R01
  assign measure_edge = run & measure_mode & pin_edge; // R16

  // Prescaler runs freely so tick phase does not depend on start timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 5'h01;
    end
  end

  logic count_tick;
  always_comb begin
    case (clock_select)
      CLK_F1_F2: count_tick = start_q[START_PRESCALE_F2_BIT] ?
                              tick_hit(prescale_q, PRESCALE_F2_MASK) : 1'b1;
      CLK_F8: count_tick = tick_hit(prescale_q, PRESCALE_F8_MASK);
      CLK_F32: count_tick = tick_hit(prescale_q, PRESCALE_F32_MASK);
      CLK_FC32: count_tick = subclock_tick;
      default: count_tick = 1'b0;
    endcase
  end // R08

  logic measure_tick;
  logic measure_wrap;
  logic event_underflow;
  assign measure_tick = run & measure_mode & count_tick;
  assign measure_wrap = measure_tick & ~measure_edge & (&counter_q); // R20
  assign event_underflow = count_event & (counter_q == '0);

  // Start phase tracking per run period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PHASE_STOPPED;
    end else begin
      case (phase_q)
        PHASE_STOPPED: begin
          // An edge in the very first run cycle is already the first one
          if (run && (count_event || measure_edge)) begin
            phase_q <= PHASE_RUNNING;
          end else if (run) begin
            phase_q <= PHASE_ARMED;
          end
        end
        PHASE_ARMED: begin
          if (!run) begin
            phase_q <= PHASE_STOPPED;
          end else if (count_event || measure_edge) begin
            phase_q <= PHASE_RUNNING;
          end
        end
        PHASE_RUNNING: if (!run) phase_q <= PHASE_STOPPED;
        default: phase_q <= PHASE_STOPPED;
      endcase
    end
  end

  // Start register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= START_REG_RESET;
    end else if (wr_start) begin
      start_q <= pwdata[7:0];
    end
  end

  // Mode register and overflow flag; a new overflow wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_REG_RESET;
    end else begin
      if (wr_mode) begin
        mode_q[7:6] <= pwdata[7:6];
        mode_q[4:0] <= pwdata[4:0];
      end
      if (measure_wrap) begin
        mode_q[OVERFLOW_FLAG_BIT] <= 1'b1; // R11
      end else if (wr_mode && ovf_armed_q && run) begin
        mode_q[OVERFLOW_FLAG_BIT] <= 1'b0; // R12
      end
    end
  end

  // Clear is only allowed once a count tick has passed since the flag was set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_armed_q <= 1'b0;
    end else if (measure_wrap || !mode_q[OVERFLOW_FLAG_BIT]) begin
      ovf_armed_q <= 1'b0;
    end else if (measure_tick) begin
      ovf_armed_q <= 1'b1; // R12
    end
  end

  // Counter and reload register
  logic early_write;
  logic [CNT_WIDTH-1:0] write_value;
  assign early_write = (phase_q != PHASE_RUNNING) & ~count_event;
  assign write_value = {lane_merge(reload_q[15:8], pwdata[15:8], pstrb[1]),
                        lane_merge(reload_q[7:0], pwdata[7:0], pstrb[0])};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_q <= COUNT_RESET;
    end else if (measure_mode) begin
      if (measure_edge) begin
        counter_q <= '0; // R09
      end else if (measure_tick) begin
        counter_q <= counter_q + 16'h0001; // R09 R20
      end
    end else if (event_mode && wr_count && early_write) begin
      counter_q <= write_value; // R06
    end else if (count_event) begin
      if (event_underflow) begin
        counter_q <= reload_q; // R02 R03
      end else begin
        counter_q <= counter_q - 16'h0001; // R02
      end
    end else if (!event_mode && wr_count && early_write) begin
      counter_q <= write_value;
    end
  end

  // In measurement mode writes are ignored and the reload holds the capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= COUNT_RESET;
    end else if (measure_mode) begin
      if (measure_edge) begin
        reload_q <= counter_q; // R09 R15
      end
    end else if (wr_count) begin
      reload_q <= write_value; // R06
    end
  end

  // Interrupt request flag; hardware set wins over accept or software clear
  logic irq_set;
  assign irq_set = event_underflow | measure_wrap |
                   (measure_edge & (phase_q == PHASE_RUNNING)); // R02 R10 R11
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_q <= 1'b0;
    end else if (irq_set) begin
      irq_flag_q <= 1'b1;
    end else if (irq_accept) begin
      irq_flag_q <= 1'b0; // R17
    end else if (wr_irq) begin
      irq_flag_q <= irq_flag_q & pwdata[IRQ_REQUEST_FLAG_BIT]; // R17
    end
  end
  assign irq_request = irq_flag_q;

  // Event pulses for the neighbouring channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underflow_event <= 1'b0;
      overflow_event <= 1'b0;
    end else begin
      underflow_event <= event_underflow;
      overflow_event <= measure_wrap;
    end
  end

  // Read data captured in the setup cycle, so the access phase needs no wait
  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h00000000;
    case (paddr)
      START_REG_OFFSET: read_mux[7:0] = start_q;
      MODE_REG_OFFSET: read_mux[7:0] = mode_q;
      COUNT_REG_OFFSET: read_mux[15:0] = measure_mode ? reload_q : counter_q; // R05 R13 R14
      IRQ_CTRL_OFFSET: read_mux[IRQ_REQUEST_FLAG_BIT] = irq_flag_q;
      default: read_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_mux;
    end
  end
endmodule : timer_b_channel

// ==== dv/timer_b_assertions.sv ====
// Port-level checker for the timer channel, bound to the channel module
`timescale 1ns/1ps
module timer_b_checker import timer_b_pkg::*; #(
  parameter int RUN_BIT = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupt and events
  input wire logic irq_accept,
  input wire logic irq_request,
  input wire logic underflow_event,
  input wire logic overflow_event
);
  logic run_q;
  logic sw_clr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign sw_clr = psel && penable && pwrite && paddr == IRQ_CTRL_OFFSET && pstrb[0]
    && !pwdata[IRQ_REQUEST_FLAG_BIT];
  // Shadow of the run bit, seen from bus writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (psel && penable && pwrite && paddr == START_REG_OFFSET && pstrb[0]) begin
      run_q <= pwdata[RUN_BIT];
    end
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_ov;
    overflow_event ##1 !overflow_event;
  endsequence
  property p_irq_hold;
    $fell(irq_request) |-> $past(irq_accept) || $past(sw_clr);
  endproperty
  property p_uf_irq;
    underflow_event |-> irq_request || $past(irq_request);
  endproperty
  property p_ov_irq;
    overflow_event |-> irq_request || $past(irq_request);
  endproperty
  property p_ov_pulse;
    $rose(overflow_event) |-> s_ov;
  endproperty
  property p_exclusive;
    !(underflow_event && overflow_event);
  endproperty
  property p_stopped;
    !run_q && !$past(run_q) && !$past(run_q, 2) |-> !underflow_event && !overflow_event;
  endproperty
  property p_ready;
    pready;
  endproperty
  property p_slverr;
    pslverr |-> s_access;
  endproperty
  property p_upper;
    prdata[31:16] == 16'h0000;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped without a clear");
  a_uf_irq: assert property (p_uf_irq) else $error("underflow without irq");
  a_ov_irq: assert property (p_ov_irq) else $error("overflow without irq");
  a_ov_pulse: assert property (p_ov_pulse) else $error("overflow pulse too long");
  a_exclusive: assert property (p_exclusive) else $error("both event pulses");
  a_stopped: assert property (p_stopped) else $error("counting while stopped");
  a_ready: assert property (p_ready) else $error("pready low");
  a_slverr: assert property (p_slverr) else $error("pslverr outside access");
  a_upper: assert property (p_upper) else $error("upper read bits set");
endmodule : timer_b_checker

bind timer_b_channel timer_b_checker #(.RUN_BIT(RUN_BIT)) i_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq_accept(irq_accept), .irq_request(irq_request),
  .underflow_event(underflow_event), .overflow_event(overflow_event));

// ==== dv/pulse_source.sv ====
// External pulse source driving the channel input pin
`timescale 1ns/1ps
module pulse_source (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic go,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  // Pin, a pure input of the channel
  output logic pin
);
  logic [8:0] ph_q;
  // Starts high, rests low; a stop during the high phase makes a falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn || !go) begin
      ph_q <= 9'h000;
      pin <= 1'b0;
    end else begin
      pin <= ph_q < {1'b0, hi_len};
      ph_q <= (ph_q == hi_len + lo_len - 9'h001) ? 9'h000 : ph_q + 9'h001;
    end
  end
endmodule : pulse_source

// ==== dv/timer_b_event_and_pulse_measure_tb_top.sv ====
// Self-checking bench for the event counter and pulse measurement channel
`timescale 1ns/1ps
module timer_b_event_and_pulse_measure_tb_top;
  import timer_b_pkg::*;
  localparam logic [31:0] RUN = 32'h1 << RUN_BIT_LOW;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic neighbour_event = 0, irq_accept = 0, subclock_tick = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, pin, irq_request, underflow_event, overflow_event, err;
  int fail_count = 0, n_checks = 0, uf_count = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (underflow_event === 1'b1) uf_count <= uf_count + 1;
  timer_b_channel i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_input_pin(pin),
    .neighbour_event(neighbour_event), .subclock_tick(subclock_tick),
    .irq_accept(irq_accept), .irq_request(irq_request),
    .underflow_event(underflow_event), .overflow_event(overflow_event));
  pulse_source i_src (.pclk(pclk), .presetn(presetn), .go(go), .hi_len(8'h0c),
    .lo_len(8'h0c), .pin(pin));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task pulses(input int n);
    repeat (n) begin
      @(posedge pclk) neighbour_event <= 1'b1;
      @(posedge pclk) neighbour_event <= 1'b0;
      cyc(2);
    end
  endtask : pulses
  task print_verdict;
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    print_verdict();
  end
  initial begin
    cyc(5);
    presetn <= 1'b1;
    apb(0, MODE_REG_OFFSET, 0);
    chk(rd, {24'h0, MODE_REG_RESET});
    apb(0, START_REG_OFFSET, 0);
    chk(rd, {24'h0, START_REG_RESET});
    apb(0, 8'h10, 0);
    chk({31'h0, err}, 32'h1);
    // Event mode fed by the neighbour channel
    apb(1, MODE_REG_OFFSET, 32'h11);
    apb(1, COUNT_REG_OFFSET, 32'h3);
    apb(0, COUNT_REG_OFFSET, 0);
    chk(rd, 32'h3);
    apb(1, START_REG_OFFSET, RUN);
    pulses(1);
    apb(0, COUNT_REG_OFFSET, 0);
    chk(rd, 32'h2);
    apb(1, COUNT_REG_OFFSET, 32'h1);
    apb(0, COUNT_REG_OFFSET, 0);
    chk(rd, 32'h2);
    pulses(3);
    chk(uf_count, 1);
    chk(irq_request, 1);
    apb(0, COUNT_REG_OFFSET, 0);
    chk(rd, 32'h1);
    pulses(2);
    chk(uf_count, 2);
    apb(1, IRQ_CTRL_OFFSET, 0);
    cyc(1);
    chk(irq_request, 0);
    pulses(2);
    @(posedge pclk) irq_accept <= 1'b1;
    @(posedge pclk) irq_accept <= 1'b0;
    cyc(1);
    chk(irq_request, 0);
    apb(1, START_REG_OFFSET, 0);
    pulses(4);
    chk(uf_count, 3);
    // Event mode fed by falling pin edges
    apb(1, MODE_REG_OFFSET, {30'h0, MODE_EVENT});
    apb(1, COUNT_REG_OFFSET, 32'h1);
    apb(1, START_REG_OFFSET, RUN);
    @(posedge pclk) go <= 1'b1;
    cyc(96);
    go <= 1'b0;
    cyc(8);
    chk(uf_count, 5);
    // Period measurement, falling to falling, undivided clock
    apb(1, START_REG_OFFSET, 0);
    apb(1, IRQ_CTRL_OFFSET, 0);
    apb(1, MODE_REG_OFFSET, {30'h0, MODE_MEASURE});
    apb(1, START_REG_OFFSET, RUN);
    @(posedge pclk) go <= 1'b1;
    cyc(18);
    chk(irq_request, 0);
    cyc(30);
    chk(irq_request, 1);
    apb(0, COUNT_REG_OFFSET, 0);
    chk(rd, 32'd23);
    apb(1, COUNT_REG_OFFSET, 32'h5555);
    apb(0, COUNT_REG_OFFSET, 0);
    chk(rd, 32'd23);
    apb(1, MODE_REG_OFFSET, {28'h0, EDGE_BOTH, MODE_MEASURE});
    cyc(60);
    apb(0, COUNT_REG_OFFSET, 0);
    chk(rd, 32'd11);
    // Overflow with the pin at rest
    go <= 1'b0;
    apb(1, MODE_REG_OFFSET, {30'h0, MODE_MEASURE});
    apb(1, IRQ_CTRL_OFFSET, 0);
    for (int i = 0; i < 70000 && overflow_event !== 1'b1; i++) @(posedge pclk);
    cyc(2);
    chk(irq_request, 1);
    apb(0, MODE_REG_OFFSET, 0);
    chk(rd[OVERFLOW_FLAG_BIT], 1);
    apb(1, MODE_REG_OFFSET, {30'h0, MODE_MEASURE});
    apb(0, MODE_REG_OFFSET, 0);
    chk(rd[OVERFLOW_FLAG_BIT], 0);
    print_verdict();
  end
endmodule : timer_b_event_and_pulse_measure_tb_top
